//--- cdmc_top.v
`timescale 1ns/1ps
`include "cdmc_regs.vh"
// What this block does
// - post codes map to 1..50 ratio table
// - output A code 99:96, B 103:100
// - output C code 107:104 or 115:112
// - output D code 111:108 or 119:116
// - PLL A ref 7:0, B 31:24
// - PLL C ref 55:48 or 79:72
// - feedback: low 3 A-count, upper 8 M
// - PLL C feedback 66:56 or 90:80
// - filter bit zero short, one long
// - filter bits 20, 44, 68 or 92
// - pump bits 19, 43, 67 or 91
// - selector codes: ref, PLL A, B, C
// - configuration cleared to zero at reset
// - divider changes apply at once; mux changes may glitch
module cdmc_top #(
	parameter CFG_W = `CDMC_CFG_W
) (
	input wire i_clock,
	input wire i_reset,
	input wire i_cfg_load,
	input wire [CFG_W-1:0] i_cfg_word,
	input wire i_alt_set_select_pin,
	input wire i_ref_en,
	input wire i_pll_a_en,
	input wire i_pll_b_en,
	input wire i_pll_c_en,
	output reg [7:0] o_pll_a_input_divider,
	output reg [7:0] o_pll_b_input_divider,
	output reg [7:0] o_pll_c_input_divider,
	output reg [2:0] o_pll_a_a_count,
	output reg [7:0] o_pll_a_m_count,
	output reg [2:0] o_pll_b_a_count,
	output reg [7:0] o_pll_b_m_count,
	output reg [2:0] o_pll_c_a_count,
	output reg [7:0] o_pll_c_m_count,
	output reg o_pll_a_filter_long,
	output reg o_pll_b_filter_long,
	output reg o_pll_c_filter_long,
	output reg o_pll_a_pump_high,
	output reg o_pll_b_pump_high,
	output reg o_pll_c_pump_high,
	output reg [1:0] o_out_a_source,
	output reg [1:0] o_out_b_source,
	output reg [1:0] o_out_c_source,
	output reg [1:0] o_out_d_source,
	output reg [3:0] o_out_a_divide_code,
	output reg [3:0] o_out_b_divide_code,
	output reg [3:0] o_out_c_divide_code,
	output reg [3:0] o_out_d_divide_code,
	output wire o_out_a_clk_en,
	output wire o_out_b_clk_en,
	output wire o_out_c_clk_en,
	output wire o_out_d_clk_en,
	output wire [CFG_W-1:0] o_cfg_word
);
	reg [CFG_W-1:0] cfg_ff;
	reg sel_ff;
	wire [3:0] src_en;
	wire [10:0] pll_a_loop_divider;
	wire [10:0] pll_b_loop_divider;
	wire [10:0] pll_c_loop_divider;

	assign src_en = {i_pll_c_en, i_pll_b_en, i_pll_a_en, i_ref_en};
	assign o_cfg_word = cfg_ff;

	// configuration store
	always @(posedge i_clock) begin
		if (i_reset) begin
			cfg_ff <= `CDMC_CFG_RST;
			sel_ff <= 1'b0;
		end else begin
			if (i_cfg_load)
				cfg_ff <= i_cfg_word;
			sel_ff <= i_alt_set_select_pin;
		end
	end

	assign pll_a_loop_divider = cfg_ff[`CDMC_LOOP_A_LSB +: 11];
	assign pll_b_loop_divider = cfg_ff[`CDMC_LOOP_B_LSB +: 11];
	assign pll_c_loop_divider = sel_ff ? cfg_ff[`CDMC_LOOP_C1_LSB +: 11] :
		cfg_ff[`CDMC_LOOP_C0_LSB +: 11];

	// decoded settings, registered
	always @(posedge i_clock) begin
		if (i_reset) begin
			o_pll_a_input_divider <= 8'h00;
			o_pll_b_input_divider <= 8'h00;
			o_pll_c_input_divider <= 8'h00;
			o_pll_a_a_count <= 3'h0;
			o_pll_a_m_count <= 8'h00;
			o_pll_b_a_count <= 3'h0;
			o_pll_b_m_count <= 8'h00;
			o_pll_c_a_count <= 3'h0;
			o_pll_c_m_count <= 8'h00;
			o_pll_a_filter_long <= 1'b0;
			o_pll_b_filter_long <= 1'b0;
			o_pll_c_filter_long <= 1'b0;
			o_pll_a_pump_high <= 1'b0;
			o_pll_b_pump_high <= 1'b0;
			o_pll_c_pump_high <= 1'b0;
			o_out_a_source <= `CDMC_SRC_REF;
			o_out_b_source <= `CDMC_SRC_REF;
			o_out_c_source <= `CDMC_SRC_REF;
			o_out_d_source <= `CDMC_SRC_REF;
			o_out_a_divide_code <= 4'h0;
			o_out_b_divide_code <= 4'h0;
			o_out_c_divide_code <= 4'h0;
			o_out_d_divide_code <= 4'h0;
		end else begin
			o_pll_a_input_divider <= cfg_ff[`CDMC_REF_A_LSB +: 8];
			o_pll_b_input_divider <= cfg_ff[`CDMC_REF_B_LSB +: 8];
			o_pll_c_input_divider <= sel_ff ?
				cfg_ff[`CDMC_REF_C1_LSB +: 8] :
				cfg_ff[`CDMC_REF_C0_LSB +: 8];
			o_pll_a_a_count <= pll_a_loop_divider[2:0];
			o_pll_a_m_count <= pll_a_loop_divider[10:3];
			o_pll_b_a_count <= pll_b_loop_divider[2:0];
			o_pll_b_m_count <= pll_b_loop_divider[10:3];
			o_pll_c_a_count <= pll_c_loop_divider[2:0];
			o_pll_c_m_count <= pll_c_loop_divider[10:3];
			// high means long loop time constant
			o_pll_a_filter_long <= cfg_ff[`CDMC_FILT_A_BIT];
			o_pll_b_filter_long <= cfg_ff[`CDMC_FILT_B_BIT];
			o_pll_c_filter_long <= sel_ff ? cfg_ff[`CDMC_FILT_C1_BIT] :
				cfg_ff[`CDMC_FILT_C0_BIT];
			o_pll_a_pump_high <= cfg_ff[`CDMC_PUMP_A_BIT];
			o_pll_b_pump_high <= cfg_ff[`CDMC_PUMP_B_BIT];
			o_pll_c_pump_high <= sel_ff ? cfg_ff[`CDMC_PUMP_C1_BIT] :
				cfg_ff[`CDMC_PUMP_C0_BIT];
			o_out_a_source <= cfg_ff[`CDMC_MUX_A_LSB +: 2];
			o_out_b_source <= cfg_ff[`CDMC_MUX_B_LSB +: 2];
			o_out_c_source <= sel_ff ? cfg_ff[`CDMC_OUT_C_SOURCE_SELECT_SET0_LSB +: 2] :
				cfg_ff[`CDMC_MUX_C0_LSB +: 2];
			o_out_d_source <= sel_ff ? cfg_ff[`CDMC_OUT_D_SOURCE_SELECT_SET0_LSB +: 2] :
				cfg_ff[`CDMC_MUX_D0_LSB +: 2];
			o_out_a_divide_code <= cfg_ff[`CDMC_POST_A_LSB +: 4];
			o_out_b_divide_code <= cfg_ff[`CDMC_POST_B_LSB +: 4];
			o_out_c_divide_code <= sel_ff ? cfg_ff[`CDMC_OUT_C_DIVIDE_CODE_SET0_LSB +: 4] :
				cfg_ff[`CDMC_POST_C0_LSB +: 4];
			o_out_d_divide_code <= sel_ff ? cfg_ff[`CDMC_OUT_D_DIVIDE_CODE_SET0_LSB +: 4] :
				cfg_ff[`CDMC_POST_D0_LSB +: 4];
		end
	end

	// four mux and post divider paths; settings change without resync
	cdmc_post_div u_post_a (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_code(o_out_a_divide_code),
		.i_src_en(src_en),
		.i_sel(o_out_a_source),
		.o_clk_en(o_out_a_clk_en)
	);
	cdmc_post_div u_post_b (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_code(o_out_b_divide_code),
		.i_src_en(src_en),
		.i_sel(o_out_b_source),
		.o_clk_en(o_out_b_clk_en)
	);
	cdmc_post_div u_post_c (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_code(o_out_c_divide_code),
		.i_src_en(src_en),
		.i_sel(o_out_c_source),
		.o_clk_en(o_out_c_clk_en)
	);
	cdmc_post_div u_post_d (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_code(o_out_d_divide_code),
		.i_src_en(src_en),
		.i_sel(o_out_d_source),
		.o_clk_en(o_out_d_clk_en)
	);
endmodule

//--- cdmc_regs.vh
`ifndef CDMC_REGS_VH
`define CDMC_REGS_VH
`define CDMC_CFG_W 128
`define CDMC_CFG_RST 128'h0
`define CDMC_REF_A_LSB 0
`define CDMC_LOOP_A_LSB 8
`define CDMC_PUMP_A_BIT 19
`define CDMC_FILT_A_BIT 20
`define CDMC_MUX_A_LSB 22
`define CDMC_REF_B_LSB 24
`define CDMC_LOOP_B_LSB 32
`define CDMC_PUMP_B_BIT 43
`define CDMC_FILT_B_BIT 44
`define CDMC_MUX_B_LSB 46
`define CDMC_REF_C0_LSB 48
`define CDMC_LOOP_C0_LSB 56
`define CDMC_PUMP_C0_BIT 67
`define CDMC_FILT_C0_BIT 68
`define CDMC_MUX_C0_LSB 70
`define CDMC_REF_C1_LSB 72
`define CDMC_LOOP_C1_LSB 80
`define CDMC_PUMP_C1_BIT 91
`define CDMC_FILT_C1_BIT 92
`define CDMC_MUX_D0_LSB 94
`define CDMC_POST_A_LSB 96
`define CDMC_POST_B_LSB 100
`define CDMC_POST_C0_LSB 104
`define CDMC_POST_D0_LSB 108
`define CDMC_OUT_C_DIVIDE_CODE_SET0_LSB 112
`define CDMC_OUT_D_DIVIDE_CODE_SET0_LSB 116
`define CDMC_OUT_C_SOURCE_SELECT_SET0_LSB 124
`define CDMC_OUT_D_SOURCE_SELECT_SET0_LSB 126
`define CDMC_SRC_REF 2'h0
`define CDMC_SRC_PLL_A 2'h1
`define CDMC_SRC_PLL_B 2'h2
`define CDMC_SRC_PLL_C 2'h3
`define CDMC_FILT_SHORT_NS 7000
`define CDMC_FILT_LONG_NS 20000
`define CDMC_PUMP_LOW_UA 2
`define CDMC_PUMP_HIGH_UA 10
`define CDMC_CLK_PERIOD_NS 25
`endif

//--- cdmc_post_div.v
`timescale 1ns/1ps
`include "cdmc_regs.vh"
module cdmc_post_div (
	input wire i_clock,
	input wire i_reset,
	input wire [3:0] i_code,
	input wire [3:0] i_src_en,
	input wire [1:0] i_sel,
	output reg o_clk_en
);
	reg [5:0] cnt_ff;
	reg [5:0] nxt_cnt;
	reg src_tick;
	reg [5:0] ratio;

	// code to divide ratio
	function [5:0] div_ratio;
		input [3:0] code;
		begin
			case (code)
				4'h0: div_ratio = 6'h01;
				4'h1: div_ratio = 6'h02;
				4'h2: div_ratio = 6'h03;
				4'h3: div_ratio = 6'h04;
				4'h4: div_ratio = 6'h05;
				4'h5: div_ratio = 6'h06;
				4'h6: div_ratio = 6'h08;
				4'h7: div_ratio = 6'h09;
				4'h8: div_ratio = 6'h0a;
				4'h9: div_ratio = 6'h0c;
				4'ha: div_ratio = 6'h0f;
				4'hb: div_ratio = 6'h10;
				4'hc: div_ratio = 6'h12;
				4'hd: div_ratio = 6'h14;
				4'he: div_ratio = 6'h19;
				default: div_ratio = 6'h32;
			endcase
		end
	endfunction

	always @* begin
		ratio = div_ratio(i_code);
		src_tick = i_src_en[i_sel];
		nxt_cnt = cnt_ff;
		if (src_tick) begin
			if (cnt_ff >= ratio - 6'h01)
				nxt_cnt = 6'h00;
			else
				nxt_cnt = cnt_ff + 6'h01;
		end
	end

	// one pulse per ratio source ticks; ratio 1 passes each tick
	always @(posedge i_clock) begin
		if (i_reset) begin
			cnt_ff <= 6'h00;
			o_clk_en <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			o_clk_en <= src_tick && (cnt_ff >= ratio - 6'h01);
		end
	end
endmodule

//--- cdmc_top_properties.sv
`timescale 1ns/1ps
module cdmc_top_props #(
	parameter CFG_W = 128
) (
	input wire i_clock,
	input wire i_reset,
	input wire i_ref_en,
	input wire i_alt_set_select_pin,
	input wire [CFG_W-1:0] o_cfg_word,
	input wire [7:0] o_pll_c_input_divider,
	input wire [2:0] o_pll_c_a_count,
	input wire [7:0] o_pll_c_m_count,
	input wire o_pll_c_filter_long,
	input wire o_pll_c_pump_high,
	input wire [1:0] o_out_a_source,
	input wire [1:0] o_out_c_source,
	input wire [1:0] o_out_d_source,
	input wire [3:0] o_out_a_divide_code,
	input wire [3:0] o_out_b_divide_code,
	input wire [3:0] o_out_c_divide_code,
	input wire [3:0] o_out_d_divide_code,
	input wire o_out_a_clk_en
);
	reg s_ff;
	reg r_ff;
	wire [CFG_W-1:0] w = o_cfg_word;
	always @(posedge i_clock) begin
		s_ff <= i_reset ? 1'b0 : i_alt_set_select_pin;
		r_ff <= i_reset;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	AST_CFG_CLR: assert property ($fell(i_reset) |-> w == 0)
		else $error("config not cleared");
	AST_POST_AB: assert property (!r_ff |->
		{o_out_b_divide_code, o_out_a_divide_code} == $past(w[103:96]))
		else $error("post code a or b wrong");
	AST_POST_C: assert property (!r_ff |->
		o_out_c_divide_code == $past(s_ff ? w[115:112] : w[107:104]))
		else $error("post code c wrong");
	AST_POST_D: assert property (!r_ff |->
		o_out_d_divide_code == $past(s_ff ? w[119:116] : w[111:108]))
		else $error("post code d wrong");
	AST_REF_C: assert property (!r_ff |->
		o_pll_c_input_divider == $past(s_ff ? w[79:72] : w[55:48]))
		else $error("pll c ref divider wrong");
	AST_LOOP_C: assert property (!r_ff |->
		{o_pll_c_m_count, o_pll_c_a_count} == $past(s_ff ? w[90:80] : w[66:56]))
		else $error("pll c loop divider wrong");
	AST_TUNE_C: assert property (!r_ff |->
		{o_pll_c_filter_long, o_pll_c_pump_high} ==
		$past(s_ff ? w[92:91] : w[68:67]))
		else $error("pll c tuning wrong");
	AST_MUX_CD: assert property (!r_ff |->
		{o_out_d_source, o_out_c_source} ==
		$past(s_ff ? w[127:124] : {w[95:94], w[71:70]}))
		else $error("source select c or d wrong");
	AST_DIV_ONE: assert property (!r_ff && o_out_a_source == 2'h0 &&
		o_out_a_divide_code == 4'h0 && i_ref_en |=> o_out_a_clk_en)
		else $error("divide by one pulse missing");
	cover property (s_ff && o_out_c_source != 2'h0);
	cover property (o_out_a_clk_en && o_out_a_divide_code == 4'hf);
	cover property ($rose(s_ff));
endmodule

//--- cdmc_board.sv
`timescale 1ns/1ps
module cdmc_board (
	input wire i_clock,
	input wire i_pin_req,
	output reg o_pin,
	output wire [3:0] o_ticks
);
	reg [7:0] cnt_ff = 8'h0;
	initial o_pin = 1'b0;
	always @(posedge i_clock) begin
		cnt_ff <= cnt_ff + 8'h1;
		o_pin <= i_pin_req;
	end
	// ref every cycle, plls every 2, 4 and 8 cycles
	assign o_ticks = {&cnt_ff[2:0], &cnt_ff[1:0], cnt_ff[0], 1'b1};
endmodule

//--- cdmc_top_tb.sv
`timescale 1ns/1ps
module cdmc_top_tb;
	logic clock, rst, ld, pq, p;
	logic [127:0] wd, w;
	logic [127:0] q[$];
	wire pin;
	wire [3:0] tk;
	wire [127:0] cw;
	wire [7:0] ra, rb, rc, ma, mb, mc;
	wire [2:0] aa, ab, ac;
	wire fa, fb, fc, pa, pb, pc;
	wire [3:0] en;
	wire [1:0] sa, sb, sc, sd;
	logic [3:0] c4, u4;
	logic [1:0] s2, t2;
	wire [3:0] ca, cb, cc, cd;
	int miscompares = 0, checked = 0, i, n, r, o;
	int dv[16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50};
	int per[4] = '{1, 2, 4, 8};
	cdmc_board u_cdmc_board (.i_clock(clock), .i_pin_req(pq), .o_pin(pin),
		.o_ticks(tk));
	cdmc_top #(.CFG_W(128)) u_cdmc_top (.i_clock(clock), .i_reset(rst),
		.i_cfg_load(ld), .i_cfg_word(wd), .i_alt_set_select_pin(pin),
		.i_ref_en(tk[0]), .i_pll_a_en(tk[1]), .i_pll_b_en(tk[2]),
		.i_pll_c_en(tk[3]), .o_pll_a_input_divider(ra),
		.o_pll_b_input_divider(rb), .o_pll_c_input_divider(rc),
		.o_pll_a_a_count(aa), .o_pll_a_m_count(ma), .o_pll_b_a_count(ab),
		.o_pll_b_m_count(mb), .o_pll_c_a_count(ac), .o_pll_c_m_count(mc),
		.o_pll_a_filter_long(fa), .o_pll_b_filter_long(fb),
		.o_pll_c_filter_long(fc), .o_pll_a_pump_high(pa),
		.o_pll_b_pump_high(pb), .o_pll_c_pump_high(pc), .o_out_a_source(sa),
		.o_out_b_source(sb), .o_out_c_source(sc), .o_out_d_source(sd),
		.o_out_a_divide_code(ca), .o_out_b_divide_code(cb),
		.o_out_c_divide_code(cc), .o_out_d_divide_code(cd),
		.o_out_a_clk_en(en[0]), .o_out_b_clk_en(en[1]),
		.o_out_c_clk_en(en[2]), .o_out_d_clk_en(en[3]),
		.o_cfg_word(cw));
	task chk(input logic [127:0] s, input logic [127:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, s, e);
		end
	endtask
	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task setw(input logic [127:0] v, input logic s);
		@(posedge clock);
		ld <= 1'b1;
		wd <= v;
		pq <= s;
		@(posedge clock);
		ld <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task gap(input int o, output int k);
		k = 0;
		while (en[o] !== 1'b1 && k < 900) begin
			@(posedge clock);
			#1;
			k++;
		end
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (en[o] !== 1'b1 && k < 900);
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#(25 * 40000);
		miscompares++;
		results;
	end
	initial begin
		rst = 1'b1;
		ld = 1'b0;
		wd = 128'h0;
		pq = 1'b0;
		r = $urandom(85);
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		chk(cw, 0);
		chk({ra, rb, rc, ma, mb, mc, cc, cd}, 0);
		$display("reset test done");
		for (i = 0; i < 16; i++) begin
			w = {$urandom, $urandom, $urandom, $urandom};
			r = $urandom;
			p = r[0];
			q.push_back(w);
			setw(w, p);
			w = q.pop_front();
			chk({rb, ra}, {w[31:24], w[7:0]});
			chk({ma, aa, mb, ab}, {w[18:8], w[42:32]});
			chk({fa, pa, fb, pb}, {w[20:19], w[44:43]});
			chk({sb, sa}, {w[47:46], w[23:22]});
			chk({cd, cc, cb, ca},
				p ? {w[119:112], w[103:96]} : w[111:96]);
			chk(rc, p ? w[79:72] : w[55:48]);
			chk({mc, ac}, p ? w[90:80] : w[66:56]);
			chk({fc, pc}, p ? w[92:91] : w[68:67]);
			chk({sd, sc}, p ? w[127:124] : {w[95:94], w[71:70]});
		end
		$display("decode test done");
		for (i = 0; i < 16; i++) begin
			c4 = i[3:0];
			u4 = ~c4;
			s2 = i[1:0];
			t2 = ~s2;
			w = 128'h0;
			w[103:96] = {c4, c4};
			w[119:104] = i[0] ? {c4, c4, u4, u4} : {u4, u4, c4, c4};
			w[23:22] = s2;
			w[47:46] = s2;
			w[71:70] = i[0] ? t2 : s2;
			w[95:94] = i[0] ? t2 : s2;
			w[127:124] = i[0] ? {s2, s2} : {t2, t2};
			setw(w, i[0]);
			for (o = 0; o < 4; o++) begin
				gap(o, n);
				gap(o, n);
				chk(n, dv[i] * per[i % 4]);
			end
		end
		$display("divider test done");
		results;
	end
endmodule
bind cdmc_top cdmc_top_props #(.CFG_W(CFG_W)) u_cdmc_top_props (
	.i_clock(i_clock),
	.i_reset(i_reset),
	.i_ref_en(i_ref_en),
	.i_alt_set_select_pin(i_alt_set_select_pin),
	.o_cfg_word(o_cfg_word),
	.o_pll_c_input_divider(o_pll_c_input_divider),
	.o_pll_c_a_count(o_pll_c_a_count),
	.o_pll_c_m_count(o_pll_c_m_count),
	.o_pll_c_filter_long(o_pll_c_filter_long),
	.o_pll_c_pump_high(o_pll_c_pump_high),
	.o_out_a_source(o_out_a_source),
	.o_out_c_source(o_out_c_source),
	.o_out_d_source(o_out_d_source),
	.o_out_a_divide_code(o_out_a_divide_code),
	.o_out_b_divide_code(o_out_b_divide_code),
	.o_out_c_divide_code(o_out_c_divide_code),
	.o_out_d_divide_code(o_out_d_divide_code),
	.o_out_a_clk_en(o_out_a_clk_en)
);
